// *** hdl/arr_ratio_ramp_regs.v ***
// converter rate-ratio, ramp-limit and mute register bank with ratio divider
//
// Overview of operation
// [R1] Eight read-only 16-bit ratio registers at 0xF582..0xF589, one per converter, reset to 0.
// [R2] Each ratio is kept updated in hardware as detected input rate over target output rate.
// [R3] The ratio is unsigned 4.12 fixed point over all 16 bits, so 0x1000 means one.
// [R4] The override register at 0xF590 holds enable in bit 11 and an 11-bit limit, reset 0x07FF.
// [R5] Eight per-converter limit registers at 0xF591..0xF598 hold an 11-bit field reset to 0x7FF.
// [R6] With override enabled all converters use the global limit, otherwise their own.
// [R7] A set block mute-disable keeps that block's four converters unmuted regardless of mutes.
// [R8] Each converter has a manual mute bit at its index, reset 0, that mutes its output.
`timescale 1ns/10ps
`default_nettype none
`include "arr_regs.vh"

module arr_ratio_ramp_regs (
    input wire clk,
    input wire rst_n,
    input wire [15:0] reg_addr,
    input wire [15:0] reg_wdata,
    input wire reg_wr,
    input wire reg_rd,
    output wire [15:0] reg_rdata,
    input wire [191:0] conv_in_rate,
    input wire [191:0] conv_out_rate,
    input wire [7:0] conv_auto_mute_req,
    output reg [87:0] conv_ramp_limit,
    output reg [7:0] conv_mute
);

    localparam [1:0] ST_LOAD = 2'd0;
    localparam [1:0] ST_RUN = 2'd1;
    localparam [1:0] ST_STORE = 2'd2;

    // true when addr falls in [base, last]
    function in_range;
        input [15:0] addr;
        input [15:0] base;
        input [15:0] last;
        begin
            in_range = (addr >= base) && (addr <= last);
        end
    endfunction

    // word index of addr inside a bank starting at base
    function [2:0] bank_index;
        input [15:0] addr;
        input [15:0] base;
        reg [15:0] diff;
        begin
            diff = addr - base;
            bank_index = diff[2:0];
        end
    endfunction

    // limit a converter uses: the global value wins while the override is on
    function [10:0] eff_limit;
        input use_ovr;
        input [10:0] ovr_value;
        input [10:0] own_value;
        begin
            eff_limit = use_ovr ? ovr_value : own_value; // R6
        end
    endfunction

    // a set block disable wins over both the manual and the automatic mute
    function eff_mute;
        input block_dis;
        input manual;
        input auto_req;
        begin
            eff_mute = !block_dis && (manual || auto_req); // R7 R8
        end
    endfunction

    // software registers
    reg ovr_enable;
    reg [10:0] ovr_limit;
    reg [10:0] chan_limit [0:7];
    reg [7:0] manual_mute;
    reg [1:0] mute_disable;

    // read path
    reg [15:0] rd_word;
    reg rd_from_ratio;
    reg [15:0] next_rd_word;

    // divider
    reg [1:0] div_state;
    reg [2:0] div_conv;
    reg [23:0] div_divisor;
    reg [35:0] div_dividend;
    reg [23:0] div_rem;
    reg [35:0] div_quot;
    reg [5:0] div_step;
    reg [1:0] next_div_state;
    reg [2:0] next_div_conv;
    reg [23:0] next_div_divisor;
    reg [35:0] next_div_dividend;
    reg [23:0] next_div_rem;
    reg [35:0] next_div_quot;
    reg [5:0] next_div_step;

    wire hit_ratio = in_range(reg_addr, `ARR_ADDR_RATIO_BASE, `ARR_ADDR_RATIO_LAST);
    wire hit_limit = in_range(reg_addr, `ARR_ADDR_LIMIT_BASE, `ARR_ADDR_LIMIT_LAST);
    wire hit_ovr = (reg_addr == `ARR_ADDR_LIMIT_OVR);
    wire hit_mute = (reg_addr == `ARR_ADDR_MUTE_CTRL);
    wire [2:0] ratio_idx = bank_index(reg_addr, `ARR_ADDR_RATIO_BASE);
    wire [2:0] limit_idx = bank_index(reg_addr, `ARR_ADDR_LIMIT_BASE);
    wire rd_ratio = reg_rd && hit_ratio;

    wire [15:0] mem_rdata;
    wire [24:0] div_trial = {div_rem, div_dividend[35]};
    wire [24:0] div_diff = div_trial - {1'b0, div_divisor};
    wire div_fits = (div_trial >= {1'b0, div_divisor});
    wire div_overflow = (div_quot[35:16] != 20'h00000);
    reg [15:0] div_result;
    wire store_ratio = (div_state == ST_STORE);

    // rate fields of each converter, picked by the divider in its load cycle
    wire [23:0] in_rate_w [0:7];
    wire [23:0] out_rate_w [0:7];

    integer i;
    genvar g;

    generate
        for (g = 0; g < 8; g = g + 1) begin : g_rate
            assign in_rate_w[g] = conv_in_rate[g * 24 +: 24];
            assign out_rate_w[g] = conv_out_rate[g * 24 +: 24];
        end
    endgenerate

    // write strobes per register; the ratio bank has none, so only hardware sets it
    wire wr_ovr = reg_wr && hit_ovr;
    wire wr_limit = reg_wr && hit_limit;
    wire wr_mute = reg_wr && hit_mute;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ovr_enable <= `ARR_OVR_EN_RST; // R4
            ovr_limit <= `ARR_LIMIT_RST; // R4
        end else if (wr_ovr) begin
            ovr_enable <= reg_wdata[`ARR_OVR_EN_BIT]; // R4
            ovr_limit <= reg_wdata[10:0]; // R4
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 8; i = i + 1) begin
                chan_limit[i] <= `ARR_LIMIT_RST; // R5
            end
        end else if (wr_limit) begin
            chan_limit[limit_idx] <= reg_wdata[10:0]; // R5
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            manual_mute <= `ARR_MUTE_RST; // R8
            mute_disable <= `ARR_MUTE_DIS_RST;
        end else if (wr_mute) begin
            manual_mute <= reg_wdata[7:0]; // R8
            mute_disable <= reg_wdata[`ARR_MUTE_DIS1_BIT:`ARR_MUTE_DIS0_BIT]; // R7
        end
    end

    // read data held for exactly the cycle after the strobe
    always @* begin
        next_rd_word = 16'h0000;
        if (reg_rd) begin
            if (hit_ovr) begin
                next_rd_word = {4'h0, ovr_enable, ovr_limit}; // R4
            end else if (hit_limit) begin
                next_rd_word = {5'h00, chan_limit[limit_idx]}; // R5
            end else if (hit_mute) begin
                next_rd_word = {6'h00, mute_disable, manual_mute};
            end
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_word <= 16'h0000;
            rd_from_ratio <= 1'b0;
        end else begin
            rd_word <= next_rd_word;
            rd_from_ratio <= rd_ratio;
        end
    end

    assign reg_rdata = rd_from_ratio ? mem_rdata : rd_word; // R1

    // saturate out-of-range ratios; a zero target rate reports zero
    always @* begin
        div_result = div_quot[15:0]; // R3
        if (div_divisor == 24'h000000) begin
            div_result = `ARR_RATIO_RST;
        end else if (div_overflow) begin
            div_result = `ARR_RATIO_SAT;
        end
    end

    // next state of the round-robin restoring divider: ratio = (in_rate << 12) / out_rate;
    // rates are sampled only in the load cycle, so a change shows on that converter's next turn
    always @* begin
        next_div_state = div_state;
        next_div_conv = div_conv;
        next_div_divisor = div_divisor;
        next_div_dividend = div_dividend;
        next_div_rem = div_rem;
        next_div_quot = div_quot;
        next_div_step = div_step;
        case (div_state)
            ST_LOAD: begin
                next_div_divisor = out_rate_w[div_conv]; // R2
                next_div_dividend = {in_rate_w[div_conv], 12'h000}; // R3
                next_div_rem = 24'h000000;
                next_div_quot = 36'h000000000;
                next_div_step = 6'd0;
                next_div_state = ST_RUN;
            end
            ST_RUN: begin
                next_div_dividend = {div_dividend[34:0], 1'b0};
                if (div_fits) begin
                    next_div_rem = div_diff[23:0];
                    next_div_quot = {div_quot[34:0], 1'b1};
                end else begin
                    next_div_rem = div_trial[23:0];
                    next_div_quot = {div_quot[34:0], 1'b0};
                end
                next_div_step = div_step + 6'd1;
                if (div_step == `ARR_DIV_LAST) begin
                    next_div_state = ST_STORE;
                end
            end
            ST_STORE: begin
                next_div_conv = div_conv + 3'd1; // R2
                next_div_state = ST_LOAD;
            end
            default: begin
                next_div_state = ST_LOAD;
            end
        endcase
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            div_state <= ST_LOAD;
            div_conv <= 3'd0;
            div_divisor <= 24'h000000;
            div_dividend <= 36'h000000000;
            div_rem <= 24'h000000;
            div_quot <= 36'h000000000;
            div_step <= 6'd0;
        end else begin
            div_state <= next_div_state;
            div_conv <= next_div_conv;
            div_divisor <= next_div_divisor;
            div_dividend <= next_div_dividend;
            div_rem <= next_div_rem;
            div_quot <= next_div_quot;
            div_step <= next_div_step;
        end
    end

    // a read of the word being stored in the same cycle returns the previous ratio
    arr_ratio_mem arr_ratio_mem_inst (
        .clk(clk),
        .rst_n(rst_n),
        .wr_en(store_ratio),
        .wr_addr(div_conv),
        .wr_data(div_result),
        .rd_en(rd_ratio),
        .rd_addr(ratio_idx),
        .rd_data(mem_rdata)
    );

    // effective limit and mute per converter, registered once for all eight
    wire [87:0] next_conv_ramp_limit;
    wire [7:0] next_conv_mute;

    generate
        for (g = 0; g < 8; g = g + 1) begin : g_conv
            assign next_conv_ramp_limit[g * 11 +: 11] = eff_limit(ovr_enable, ovr_limit, // R6
                chan_limit[g]);
            assign next_conv_mute[g] = eff_mute(mute_disable[g / 4], manual_mute[g], // R7
                conv_auto_mute_req[g]); // R8
        end
    endgenerate

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            conv_ramp_limit <= {8{`ARR_LIMIT_RST}};
            conv_mute <= 8'h00;
        end else begin
            conv_ramp_limit <= next_conv_ramp_limit;
            conv_mute <= next_conv_mute;
        end
    end

endmodule

`default_nettype wire

// *** hdl/arr_regs.vh ***
// register offsets, field positions, reset values and counts of the converter ratio/ramp bank
`ifndef ARR_REGS_VH
`define ARR_REGS_VH

`define ARR_NUM_CONV 8
`define ARR_DATA_W 16
`define ARR_ADDR_W 16
`define ARR_RATE_W 24
`define ARR_LIMIT_W 11
`define ARR_FRAC_BITS 12
`define ARR_DIV_STEPS 6'd36
`define ARR_DIV_LAST 6'd35

`define ARR_ADDR_MUTE_CTRL 16'hF580
`define ARR_ADDR_RATIO_BASE 16'hF582
`define ARR_ADDR_RATIO_LAST 16'hF589
`define ARR_ADDR_LIMIT_OVR 16'hF590
`define ARR_ADDR_LIMIT_BASE 16'hF591
`define ARR_ADDR_LIMIT_LAST 16'hF598

`define ARR_RATIO_RST 16'h0000
`define ARR_RATIO_SAT 16'hFFFF
`define ARR_LIMIT_RST 11'h7FF
`define ARR_OVR_EN_RST 1'b0
`define ARR_OVR_EN_BIT 11
`define ARR_MUTE_RST 8'h00
`define ARR_MUTE_DIS_RST 2'b00
`define ARR_MUTE_DIS0_BIT 8
`define ARR_MUTE_DIS1_BIT 9

`endif

// *** hdl/arr_ratio_mem.v ***
// eight-word ratio store with one write port and a registered read port
`timescale 1ns/10ps
`default_nettype none
`include "arr_regs.vh"

module arr_ratio_mem (
    input wire clk,
    input wire rst_n,
    input wire wr_en,
    input wire [2:0] wr_addr,
    input wire [15:0] wr_data,
    input wire rd_en,
    input wire [2:0] rd_addr,
    output reg [15:0] rd_data
);

    reg [15:0] mem [0:7];
    integer i;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            for (i = 0; i < 8; i = i + 1) begin
                mem[i] <= `ARR_RATIO_RST; // R1
            end
        end else if (wr_en) begin
            mem[wr_addr] <= wr_data;
        end
    end

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_data <= `ARR_RATIO_RST;
        end else if (rd_en) begin
            rd_data <= mem[rd_addr];
        end
    end

endmodule

`default_nettype wire

// *** dv/arr_ratio_ramp_regs_props.sv ***
// assertion checker for the converter ratio, ramp-limit and mute register bank
`timescale 1ns/10ps
`default_nettype none
module arr_ratio_ramp_regs_props (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire logic [191:0] conv_in_rate,
    input wire logic [191:0] conv_out_rate,
    input wire logic [7:0] conv_auto_mute_req,
    input wire logic [87:0] conv_ramp_limit,
    input wire logic [7:0] conv_mute
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire mute_wr = reg_wr && reg_addr == 16'hF580;
    AST_RDATA_IDLE: assert property (reg_rdata != 16'h0000 |-> $past(reg_rd))
        else $error("read data outside its answer cycle");
    AST_RESET_OUT: assert property ($rose(rst_n) |-> conv_ramp_limit == {8{11'h7FF}}
        && conv_mute == 8'h00) else $error("outputs wrong after reset");
    AST_OVR_ALL: assert property (reg_wr && reg_addr == 16'hF590 && reg_wdata[11] ##1 !reg_wr
        |=> conv_ramp_limit == {8{$past(reg_wdata[10:0], 2)}}) else $error("override not applied");
    AST_DIS0: assert property (mute_wr && reg_wdata[8] ##1 !mute_wr |=> conv_mute[3:0] == 4'h0)
        else $error("block 0 muted while disabled");
    AST_DIS1: assert property (mute_wr && reg_wdata[9] ##1 !mute_wr |=> conv_mute[7:4] == 4'h0)
        else $error("block 1 muted while disabled");
    AST_MANUAL: assert property (mute_wr && reg_wdata[9:8] == 2'b00 ##1 !mute_wr
        |=> conv_mute == ($past(reg_wdata[7:0], 2) | $past(conv_auto_mute_req)))
        else $error("mute output wrong");
    AST_OVR_RSV: assert property ($past(reg_rd) && $past(reg_addr) == 16'hF590
        |-> reg_rdata[15:12] == 4'h0) else $error("override reserved bits set");
    AST_LIM_RSV: assert property ($past(reg_rd) && $past(reg_addr) >= 16'hF591
        && $past(reg_addr) <= 16'hF598 |-> reg_rdata[15:11] == 5'h00)
        else $error("limit reserved bits set");
    cover property (mute_wr && reg_wdata[8]);
    cover property (reg_wr && reg_addr == 16'hF590 && reg_wdata[11]);
    cover property (reg_rd && reg_addr == 16'hF582);
endmodule
bind arr_ratio_ramp_regs arr_ratio_ramp_regs_props arr_ratio_ramp_regs_props_inst (
    .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_in_rate(conv_in_rate),
    .conv_out_rate(conv_out_rate), .conv_auto_mute_req(conv_auto_mute_req),
    .conv_ramp_limit(conv_ramp_limit), .conv_mute(conv_mute));
`default_nettype wire

// *** dv/arr_ratio_ramp_regs_tb.sv ***
// self-checking bench for the converter ratio, ramp-limit and mute register bank
`timescale 1ns/10ps
`default_nettype none
module arr_ratio_ramp_regs_tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [191:0] conv_in_rate = '0;
    logic [191:0] conv_out_rate = '0;
    logic [7:0] conv_auto_mute_req = 8'h00;
    wire [15:0] reg_rdata;
    wire [87:0] conv_ramp_limit;
    wire [7:0] conv_mute;
    logic [87:0] own;
    int fails = 0;
    int tests_run = 0;
    int cycles = 0;
    always #12.5 clk = ~clk;
    arr_ratio_ramp_regs arr_ratio_ramp_regs_inst (
        .clk(clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .conv_in_rate(conv_in_rate),
        .conv_out_rate(conv_out_rate), .conv_auto_mute_req(conv_auto_mute_req),
        .conv_ramp_limit(conv_ramp_limit), .conv_mute(conv_mute));
    task automatic results;
        if (fails == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task automatic chk(input string what, input logic [87:0] exp, input logic [87:0] got);
        tests_run++;
        if (got !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr <= 1'b0;
    endtask
    // read data are looked at only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd <= 1'b0;
        #1 chk("reg_rdata", {72'h0, e}, {72'h0, reg_rdata});
    endtask
    task automatic mute(input logic [15:0] d, input logic [7:0] a, input logic [7:0] e);
        conv_auto_mute_req <= a;
        wr(16'hF580, d);
        rd(16'hF580, d & 16'h03FF);
        chk("conv_mute", {80'h0, e}, {80'h0, conv_mute});
    endtask
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            fails++;
            results;
        end
    end
    initial begin
        repeat (10) @(posedge clk);
        for (int i = 0; i < 8; i++)
            conv_in_rate[24*i +: 24] <= 24'(1000 * (i + 2));
        rst_n <= 1'b1;
        #1 chk("conv_ramp_limit", {8{11'h7FF}}, conv_ramp_limit);
        chk("conv_mute", 88'h0, {80'h0, conv_mute});
        rd(16'hF580, 16'h0000);
        rd(16'hF590, 16'h07FF);
        rd(16'hF581, 16'h0000);
        rd(16'hF599, 16'h0000);
        for (int i = 0; i < 8; i++) begin
            rd(16'hF582 + 16'(i), 16'h0000);
            rd(16'hF591 + 16'(i), 16'h07FF);
        end
        // with no target rate every ratio reads zero, so a landed write would show
        wr(16'hF582, 16'hFFFF);
        rd(16'hF582, 16'h0000);
        // target rate doubles on the second pass so every ratio must halve
        for (int k = 0; k < 2; k++) begin
            conv_out_rate <= {8{24'd2000 << k}};
            wr(16'hF582, 16'hFFFF);
            repeat (400) @(posedge clk);
            for (int i = 0; i < 8; i++)
                rd(16'hF582 + 16'(i), 16'((i + 2) * 2048 >> k));
        end
        // a target rate far below the input rate pushes every ratio past 16.0
        conv_out_rate <= {8{24'd100}};
        repeat (400) @(posedge clk);
        for (int i = 0; i < 8; i++)
            rd(16'hF582 + 16'(i), 16'hFFFF);
        for (int i = 0; i < 8; i++) begin
            own[11*i +: 11] = 11'(i * 241 + 3);
            wr(16'hF591 + 16'(i), {5'h1F, own[11*i +: 11]});
            rd(16'hF591 + 16'(i), {5'h00, own[11*i +: 11]});
        end
        chk("conv_ramp_limit", own, conv_ramp_limit);
        wr(16'hF590, 16'hF923);
        rd(16'hF590, 16'h0923);
        chk("conv_ramp_limit", {8{11'h123}}, conv_ramp_limit);
        wr(16'hF590, 16'h0123);
        rd(16'hF590, 16'h0123);
        chk("conv_ramp_limit", own, conv_ramp_limit);
        mute(16'h00A5, 8'h00, 8'hA5);
        mute(16'h01A5, 8'h00, 8'hA0);
        mute(16'h0200, 8'h0F, 8'h0F);
        mute(16'h0300, 8'hFF, 8'h00);
        mute(16'h0000, 8'hF0, 8'hF0);
        mute(16'hFC3C, 8'h00, 8'h3C);
        results;
    end
endmodule
`default_nettype wire
